/* rtl/sfw_pkg.sv */
// constants and register map of the serial fifo level and watermark block
package sfw_pkg;
  localparam int DATA_W = 16;
  localparam int DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  localparam int WM_W = 4;
  localparam int ADDR_W = 8;
  localparam int ST_W = 4;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_RXDATA = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_TXDATA = 8'h14;
  // ---------------------------------------------------------------
  // fifo_control_reg fields
  // ---------------------------------------------------------------
  localparam int CTL_RXRST_BIT = 9;
  localparam int CTL_TXRST_BIT = 8;
  localparam int CTL_RXWM_LSB = 4;
  localparam int CTL_TXWM_LSB = 0;
  localparam int CTL_W = 10;
  localparam logic [CTL_W-1:0] CTL_RESET = 10'h000;
  // ---------------------------------------------------------------
  // fifo_level_counts fields
  // ---------------------------------------------------------------
  localparam int CNT_RX_LSB = 8;
  localparam int CNT_TX_LSB = 0;
  localparam logic [CNT_W-1:0] CNT_EMPTY = 5'h00;
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
  // ---------------------------------------------------------------
  // serial_status_reg bits; 3:0 sticky, 5:4 live flags
  // ---------------------------------------------------------------
  localparam int ST_RXRDY = 0;
  localparam int ST_TXEMP = 1;
  localparam int ST_OVR = 2;
  localparam int ST_UND = 3;
  localparam int ST_LIVE_RX = 4;
  localparam int ST_LIVE_TX = 5;
endpackage

/* rtl/sfw_top.sv */
// fifo occupancy, watermark flags and wishbone registers of the serial codec port
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
// Contract
// RL1: transmit fifo stays in reset while its soft reset bit is one.
// RL2: receive ready flag is high while receive count reaches the receive watermark.
// RL3: receive watermark code n means level n plus one; reset gives level one.
// RL4: transmit empty flag is high while transmit count is at most its watermark.
// RL5: transmit watermark code n means level n; reset gives level zero.
// RL6: count register shows receive count in bits 12..8; writes ignored.
// RL7: count register shows untransmitted transmit count in bits 4..0.
// RL8: each count reads 0x00 when empty and 0x10 when full.
// RL9: counts are zero after reset and while the fifo soft resets are set.
// RL10: receive count returns to zero when every entry has been read.
// RL11: transmit count returns to zero when every entry has been shifted out.
// RL12: reserved count bits 15..13 and 7..5 read zero.
// RL13: transmit soft reset empties fifo and clears underrun and empty events.
// RL14: receive soft reset empties fifo and clears overrun and ready events.
// RL15: counts follow pushes and pops; flags follow counts every cycle.
module sfw_top (
  input wire logic clock,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [sfw_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rx_push,
  input wire logic [sfw_pkg::DATA_W-1:0] rx_push_data,
  input wire logic tx_pop,
  output logic [sfw_pkg::DATA_W-1:0] tx_pop_data,
  output logic rx_ready_flag,
  output logic tx_empty_flag,
  output logic irq
);
  import sfw_pkg::*;

  logic ack_r;
  logic [31:0] dat_r;
  logic [CTL_W-1:0] ctl_r;
  logic [ST_W-1:0] st_r;
  logic [ST_W-1:0] mask_r;
  logic [DATA_W-1:0] rx_mem [DEPTH];
  logic [DATA_W-1:0] tx_mem [DEPTH];
  logic [PTR_W-1:0] rx_wp_r;
  logic [PTR_W-1:0] rx_rp_r;
  logic [PTR_W-1:0] tx_wp_r;
  logic [PTR_W-1:0] tx_rp_r;
  logic [CNT_W-1:0] rx_cnt_r;
  logic [CNT_W-1:0] tx_cnt_r;
  logic [DATA_W-1:0] tx_out_r;
  logic rx_ready_q_r;
  logic tx_empty_q_r;
  logic bus_go;
  logic bus_wr;
  logic bus_rd;
  logic rx_fifo_soft_reset;
  logic tx_fifo_soft_reset;
  logic [WM_W-1:0] rx_watermark_level;
  logic [WM_W-1:0] tx_watermark_level;
  logic [CNT_W-1:0] rx_level;
  logic rx_push_ok;
  logic rx_pop_ok;
  logic tx_push_ok;
  logic tx_pop_ok;
  logic [ST_W-1:0] st_evt;
  logic [ST_W-1:0] st_clr;
  logic [15:0] fifo_level_counts;
  logic [31:0] rd_mux;

  // ---------------------------------------------------------------
  // wishbone slave: one wait state, ack for one cycle
  // ---------------------------------------------------------------
  // side effects fire on the edge that raises ack, so read data and pop agree
  assign bus_go = wb_cyc_i && wb_stb_i && !ack_r;
  assign bus_wr = bus_go && wb_we_i && wb_sel_i[0];
  assign bus_rd = bus_go && !wb_we_i;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  always_ff @(posedge clock)
  begin
    if (rst)
      ack_r <= 1'b0;
    else
      ack_r <= bus_go;
  end

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (wb_adr_i)
      OFF_CTRL: rd_mux = {{(32-CTL_W){1'b0}}, ctl_r};
      OFF_COUNT: rd_mux = {16'h0000, fifo_level_counts};
      OFF_STATUS: rd_mux = {26'h000_0000, tx_empty_flag, rx_ready_flag, st_r};
      OFF_MASK: rd_mux = {28'h000_0000, mask_r};
      OFF_RXDATA: rd_mux = rx_pop_ok ? {16'h0000, rx_mem[rx_rp_r]} : 32'h0000_0000;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      dat_r <= 32'h0000_0000;
    else if (bus_rd)
      dat_r <= rd_mux;
  end

  // ---------------------------------------------------------------
  // control and mask registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
      ctl_r <= CTL_RESET; // RL3 RL5
    else if (bus_wr && wb_adr_i == OFF_CTRL)
    begin
      // the soft reset bits persist until software writes them back to zero
      ctl_r[CTL_TXRST_BIT-1:0] <= wb_dat_i[CTL_TXRST_BIT-1:0];
      if (wb_sel_i[1])
        ctl_r[CTL_W-1:CTL_TXRST_BIT] <= wb_dat_i[CTL_W-1:CTL_TXRST_BIT]; // RL1
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      mask_r <= '0;
    else if (bus_wr && wb_adr_i == OFF_MASK)
      mask_r <= wb_dat_i[ST_W-1:0];
  end

  assign rx_fifo_soft_reset = ctl_r[CTL_RXRST_BIT];
  assign tx_fifo_soft_reset = ctl_r[CTL_TXRST_BIT];
  assign rx_watermark_level = ctl_r[CTL_RXWM_LSB +: WM_W];
  assign tx_watermark_level = ctl_r[CTL_TXWM_LSB +: WM_W];

  // ---------------------------------------------------------------
  // receive fifo: serial engine fills, bus drains
  // ---------------------------------------------------------------
  assign rx_push_ok = rx_push && rx_cnt_r != CNT_FULL && !rx_fifo_soft_reset;
  assign rx_pop_ok = bus_rd && wb_adr_i == OFF_RXDATA && rx_cnt_r != CNT_EMPTY
    && !rx_fifo_soft_reset;

  always_ff @(posedge clock)
  begin
    if (rx_push_ok)
      rx_mem[rx_wp_r] <= rx_push_data;
  end

  always_ff @(posedge clock)
  begin
    if (rst || rx_fifo_soft_reset)
    begin
      rx_wp_r <= '0; // RL9 RL14
      rx_rp_r <= '0;
      rx_cnt_r <= CNT_EMPTY;
    end
    else
    begin
      if (rx_push_ok)
        rx_wp_r <= rx_wp_r + 1'b1;
      if (rx_pop_ok)
        rx_rp_r <= rx_rp_r + 1'b1;
      if (rx_push_ok && !rx_pop_ok)
        rx_cnt_r <= rx_cnt_r + CNT_ONE; // RL15
      else if (rx_pop_ok && !rx_push_ok)
        rx_cnt_r <= rx_cnt_r - CNT_ONE; // RL10
    end
  end

  // ---------------------------------------------------------------
  // transmit fifo: bus fills, serial engine drains
  // ---------------------------------------------------------------
  // a write to a full fifo is dropped; software should watch the count first
  assign tx_push_ok = bus_wr && wb_adr_i == OFF_TXDATA && tx_cnt_r != CNT_FULL
    && !tx_fifo_soft_reset;
  assign tx_pop_ok = tx_pop && tx_cnt_r != CNT_EMPTY && !tx_fifo_soft_reset;

  always_ff @(posedge clock)
  begin
    if (tx_push_ok)
      tx_mem[tx_wp_r] <= wb_dat_i[DATA_W-1:0];
  end

  always_ff @(posedge clock)
  begin
    if (rst || tx_fifo_soft_reset)
    begin
      tx_wp_r <= '0; // RL1 RL9 RL13
      tx_rp_r <= '0;
      tx_cnt_r <= CNT_EMPTY;
    end
    else
    begin
      if (tx_push_ok)
        tx_wp_r <= tx_wp_r + 1'b1;
      if (tx_pop_ok)
        tx_rp_r <= tx_rp_r + 1'b1;
      if (tx_push_ok && !tx_pop_ok)
        tx_cnt_r <= tx_cnt_r + CNT_ONE; // RL15
      else if (tx_pop_ok && !tx_push_ok)
        tx_cnt_r <= tx_cnt_r - CNT_ONE; // RL11
    end
  end

  // an underrun shifts out zero rather than stale data
  always_ff @(posedge clock)
  begin
    if (rst)
      tx_out_r <= '0;
    else if (tx_pop)
      tx_out_r <= tx_pop_ok ? tx_mem[tx_rp_r] : '0;
  end
  assign tx_pop_data = tx_out_r;

  // ---------------------------------------------------------------
  // watermark flags and count register
  // ---------------------------------------------------------------
  assign rx_level = {1'b0, rx_watermark_level} + CNT_ONE; // RL3
  assign rx_ready_flag = rx_cnt_r >= rx_level; // RL2 RL15
  assign tx_empty_flag = tx_cnt_r <= {1'b0, tx_watermark_level}; // RL4 RL5
  // RL6 RL7 RL8 RL12
  assign fifo_level_counts = {3'b000, rx_cnt_r, 3'b000, tx_cnt_r};

  // ---------------------------------------------------------------
  // sticky status, write one to clear, masked interrupt
  // ---------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rx_ready_q_r <= 1'b0;
      tx_empty_q_r <= 1'b0;
    end
    else
    begin
      rx_ready_q_r <= rx_ready_flag;
      tx_empty_q_r <= tx_empty_flag;
    end
  end

  always_comb
  begin
    st_evt = '0;
    st_evt[ST_RXRDY] = rx_ready_flag && !rx_ready_q_r;
    st_evt[ST_TXEMP] = tx_empty_flag && !tx_empty_q_r;
    st_evt[ST_OVR] = rx_push && rx_cnt_r == CNT_FULL && !rx_fifo_soft_reset;
    st_evt[ST_UND] = tx_pop && tx_cnt_r == CNT_EMPTY && !tx_fifo_soft_reset;
    st_clr = (bus_wr && wb_adr_i == OFF_STATUS) ? wb_dat_i[ST_W-1:0] : '0;
    st_clr[ST_RXRDY] = st_clr[ST_RXRDY] || rx_fifo_soft_reset; // RL14
    st_clr[ST_OVR] = st_clr[ST_OVR] || rx_fifo_soft_reset;
    st_clr[ST_TXEMP] = st_clr[ST_TXEMP] || tx_fifo_soft_reset; // RL13
    st_clr[ST_UND] = st_clr[ST_UND] || tx_fifo_soft_reset;
  end

  // a new event beats a clear in the same cycle
  always_ff @(posedge clock)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= (st_r & ~st_clr) | st_evt;
  end

  assign irq = |(st_r & mask_r);

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence rx_push_only_s;
    rx_push_ok && !rx_pop_ok;
  endsequence

  sequence tx_last_out_s;
    tx_cnt_r == CNT_ONE && tx_pop && !tx_push_ok && !tx_fifo_soft_reset;
  endsequence

  chk_tx_reset_hold: assert property (tx_fifo_soft_reset |=> tx_cnt_r == CNT_EMPTY) // RL1
    else $error("transmit count not held empty during soft reset");
  chk_rx_ready_level: assert property (
    rx_cnt_r == {1'b0, rx_watermark_level} + CNT_ONE |-> rx_ready_flag) // RL2
    else $error("receive ready missing at watermark");
  chk_rx_below_level: assert property (
    rx_cnt_r == {1'b0, rx_watermark_level} |-> !rx_ready_flag) // RL3
    else $error("receive ready set below watermark");
  chk_tx_empty_level: assert property (
    tx_cnt_r == {1'b0, tx_watermark_level} + CNT_ONE |-> !tx_empty_flag) // RL4 RL5
    else $error("transmit empty set above watermark");
  chk_count_read_fmt: assert property (
    bus_rd && wb_adr_i == OFF_COUNT |=> wb_ack_o && wb_dat_o[15:13] == 3'b000
    && wb_dat_o[7:5] == 3'b000 && wb_dat_o[12:8] == $past(rx_cnt_r)) // RL6 RL12
    else $error("count register read wrong");
  chk_count_bound: assert property (rx_cnt_r <= CNT_FULL && tx_cnt_r <= CNT_FULL) // RL8
    else $error("fifo count beyond full");
  chk_rx_reset_clear: assert property (
    rx_fifo_soft_reset |=> rx_cnt_r == CNT_EMPTY && !st_r[ST_OVR]) // RL9 RL14
    else $error("receive soft reset left state");
  chk_rx_push_count: assert property (
    rx_push_only_s |=> rx_cnt_r == $past(rx_cnt_r) + CNT_ONE) // RL15
    else $error("receive count did not increment");
  chk_rx_drain: assert property (
    rx_cnt_r == CNT_ONE && rx_pop_ok && !rx_push_ok |=> rx_cnt_r == CNT_EMPTY) // RL10
    else $error("receive count not zero after last read");
  chk_tx_drain: assert property (tx_last_out_s |=> tx_cnt_r == CNT_EMPTY) // RL11
    else $error("transmit count not zero after last shift");
  chk_tx_reset_flags: assert property (
    tx_fifo_soft_reset && !st_evt[ST_UND] |=> !st_r[ST_UND]) // RL13
    else $error("underrun survived transmit soft reset");
endmodule

/* verif/sfw_top_bench.sv */
// self-checking bench for the serial fifo level and watermark block
`timescale 1ns/10ps
module sfw_top_bench;
  import sfw_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [ADDR_W-1:0] adr = 8'h00;
  logic [3:0] sel = 4'hf;
  logic [31:0] dat = 32'h0, dat_o, q;
  logic ack, rx_push = 1'b0, tx_pop = 1'b0, rx_ready_flag, tx_empty_flag, irq;
  logic [DATA_W-1:0] rx_push_data = 16'h0, tx_pop_data;
  logic [31:0] seed = 32'h21;
  int failures = 0, cmp_count = 0, k, c;
  logic [15:0] rxq[$], txq[$];

  sfw_top i_dut (.clock(clock), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .rx_push(rx_push), .rx_push_data(rx_push_data), .tx_pop(tx_pop),
    .tx_pop_data(tx_pop_data), .rx_ready_flag(rx_ready_flag),
    .tx_empty_flag(tx_empty_flag), .irq(irq));

  always #2 clock = ~clock;

  function automatic logic [15:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[15:0];
  endfunction

  // expected count word from the bench queues; reserved bits stay zero
  function automatic logic [31:0] cnt_word();
    logic [31:0] w;
    w = 32'h0;
    w[12:8] = CNT_W'(rxq.size());
    w[4:0] = CNT_W'(txq.size());
    return w;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one classic cycle; the slave answer time is not assumed
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h1, 32'(ack));
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    #1;
  endtask

  task automatic push_rx();
    @(posedge clock);
    rx_push <= 1'b1;
    rx_push_data <= xs();
    @(posedge clock);
    rx_push <= 1'b0;
    if (rxq.size() < DEPTH) rxq.push_back(rx_push_data);
  endtask

  task automatic pop_tx();
    @(posedge clock);
    tx_pop <= 1'b1;
    @(posedge clock);
    tx_pop <= 1'b0;
    #1;
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #(40000 * 4);
    failures++;
    wrap_up();
  end

  initial
  begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    wb(1'b0, OFF_COUNT, 32'h0);
    chk("count", 32'h0, q);
    chk("tx_empty_flag", 32'h1, 32'(tx_empty_flag));
    chk("rx_ready_flag", 32'h0, 32'(rx_ready_flag));
    $display("test reset done");
    // sweep every watermark code at every fill level, both fifos together
    for (k = 0; k <= DEPTH; k++)
    begin
      for (c = 0; c < 16; c++)
      begin
        wb(1'b1, OFF_CTRL, 32'(c * 16 + c));
        chk("rx_ready_flag", 32'(k >= c + 1), 32'(rx_ready_flag));
        chk("tx_empty_flag", 32'(k <= c), 32'(tx_empty_flag));
      end
      wb(1'b0, OFF_COUNT, 32'h0);
      chk("count", cnt_word(), q);
      if (k < DEPTH)
      begin
        push_rx();
        txq.push_back(xs());
        wb(1'b1, OFF_TXDATA, {16'h0, txq[$]});
      end
    end
    $display("test watermark sweep done");
    wb(1'b1, OFF_STATUS, 32'hf);
    push_rx();
    wb(1'b1, OFF_COUNT, 32'hffff);
    wb(1'b0, OFF_COUNT, 32'h0);
    chk("full count", 32'h1010, q);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk("overrun", 32'h4, q & 32'h4);
    wb(1'b1, OFF_MASK, 32'h4);
    chk("irq", 32'h1, 32'(irq));
    wb(1'b1, OFF_MASK, 32'h0);
    chk("irq", 32'h0, 32'(irq));
    wb(1'b1, OFF_STATUS, 32'h4);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk("overrun", 32'h0, q & 32'h4);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("test refusals and interrupt done");
    while (rxq.size() > 0)
    begin
      wb(1'b0, OFF_RXDATA, 32'h0);
      chk("rx data", {16'h0, rxq.pop_front()}, q);
    end
    while (txq.size() > 0)
    begin
      pop_tx();
      chk("tx data", {16'h0, txq.pop_front()}, {16'h0, tx_pop_data});
    end
    wb(1'b0, OFF_COUNT, 32'h0);
    chk("drained count", 32'h0, q);
    pop_tx();
    wb(1'b0, OFF_STATUS, 32'h0);
    chk("underrun", 32'h8, q & 32'h8);
    chk("underrun data", 32'h0, {16'h0, tx_pop_data});
    // tx empty rose during the drain, live tx empty high, live rx ready low
    chk("status", 32'h2a, q & 32'h3f);
    $display("test drain done");
    repeat (3)
    begin
      push_rx();
      txq.push_back(xs());
      wb(1'b1, OFF_TXDATA, {16'h0, txq[$]});
    end
    wb(1'b1, OFF_CTRL, 32'h100);
    txq.delete();
    wb(1'b1, OFF_TXDATA, 32'h1234);
    wb(1'b0, OFF_COUNT, 32'h0);
    chk("tx reset count", cnt_word(), q);
    chk("tx_empty_flag", 32'h1, 32'(tx_empty_flag));
    wb(1'b0, OFF_STATUS, 32'h0);
    chk("tx events", 32'h0, q & 32'ha);
    wb(1'b1, OFF_CTRL, 32'h300);
    rxq.delete();
    wb(1'b0, OFF_COUNT, 32'h0);
    chk("both reset count", 32'h0, q);
    wb(1'b0, OFF_STATUS, 32'h0);
    chk("rx events", 32'h0, q & 32'h5);
    chk("rx_ready_flag", 32'h0, 32'(rx_ready_flag));
    wb(1'b1, OFF_CTRL, 32'h0);
    txq.push_back(16'h00a5);
    wb(1'b1, OFF_TXDATA, 32'h00a5);
    wb(1'b0, OFF_COUNT, 32'h0);
    chk("count after release", cnt_word(), q);
    $display("test soft reset done");
    wrap_up();
  end
endmodule
